// *** pkg/clock_generator_regs.vh ***
// Constants shared by the clock generator design files
`ifndef CLOCK_GENERATOR_REGS_VH
`define CLOCK_GENERATOR_REGS_VH

// Core clock and derived timing
`define CLK_HZ              100000000
`define CLK_MHZ             100
`define INT_REF_HZ          32000
`define INT_REF_CYCLES      (`CLK_HZ / `INT_REF_HZ)
`define LOC_TIME_LOW_US     100
`define LOC_TIME_HIGH_US    10
`define OSC_STARTUP_LAST    12'hfff
`define LOCK_TOLERANCE      16'h0002

// Loop multiplication
`define FLL_FACTOR          11'h400
`define PLL_FACTOR_SHIFT    2

// Clock source select / status codes
`define CLOCK_SOURCE_SELECT_LOOP           2'h0
`define CLOCK_SOURCE_SELECT_INTERNAL       2'h1
`define CLOCK_SOURCE_SELECT_EXTERNAL       2'h2
`define CLOCK_SOURCE_SELECT_PLL            2'h3

// Bus divider and reference divider codes
`define BUS_FREQUENCY_DIVIDER_DIV1           2'h0
`define BUS_FREQUENCY_DIVIDER_DIV2           2'h1
`define REFERENCE_DIVIDER_MIN_DIV1       3'h2
`define REFERENCE_DIVIDER_MIN_DIV2       3'h3

// Reset values of the control fields
`define RST_CLOCK_SOURCE_SELECT            2'h0
`define RST_INTERNAL_REF_SELECT           1'b1
`define RST_BUS_FREQUENCY_DIVIDER            2'h1
`define RST_REFERENCE_DIVIDER            3'h0
`define RST_PLL_MULTIPLIER_SELECT            4'h1

// Operating mode codes
`define MODE_FEI            3'h0
`define MODE_FEE            3'h1
`define MODE_FBI            3'h2
`define MODE_FBE            3'h3
`define MODE_PEE            3'h4
`define MODE_PBE            3'h5
`define MODE_LOW_POWER_BYPASSED_INTERNAL_MODE           3'h6
`define MODE_LOW_POWER_BYPASSED_EXTERNAL_MODE           3'h7

`endif

// *** logic/tick_power2_divider.v ***
// Divides a tick stream by a power of two chosen by a three-bit code
`timescale 1ns/10ps
module tick_power2_divider (
  input  wire       clk_i,
  input  wire       reset_i,
  input  wire       tick_i,
  input  wire [2:0] code_i,
  output reg        tick_o
);
  reg  [6:0] count_r;
  wire [6:0] mask_w;

  function [6:0] code_mask;
    input [2:0] code;
    reg   [7:0] m;
    begin
      m = (8'h01 << code) - 8'h01;
      code_mask = m[6:0];
    end
  endfunction

  assign mask_w = code_mask(code_i);

  // Masked compare tolerates a code change mid-count without a long stall
  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      count_r <= 7'h00;
      tick_o  <= 1'b0;
    end
    else
    begin
      tick_o <= 1'b0;
      if (tick_i)
      begin
        if ((count_r & mask_w) == mask_w)
        begin
          count_r <= 7'h00;
          tick_o  <= 1'b1;
        end
        else
        begin
          count_r <= count_r + 7'h01;
        end
      end
    end
  end
endmodule

// *** logic/clock_generator.v ***
// Multi-mode clock generator: reference paths, loop model, mode status, monitor
`timescale 1ns/10ps
`include "clock_generator_regs.vh"
module clock_generator #(
  parameter [15:0] LOC_CYCLES_LOW  = `LOC_TIME_LOW_US * `CLK_MHZ,
  parameter [15:0] LOC_CYCLES_HIGH = `LOC_TIME_HIGH_US * `CLK_MHZ
) (
  input  wire       clk_i,
  input  wire       reset_i,
  input  wire       power_on_i,
  input  wire       ext_ref_clock_i,
  input  wire       stop_i,
  input  wire       debug_active_i,
  input  wire       control_write_i,
  input  wire [1:0] clock_source_select_i,
  input  wire       internal_ref_select_i,
  input  wire       loop_select_i,
  input  wire       low_power_i,
  input  wire [2:0] reference_divider_i,
  input  wire [1:0] bus_frequency_divider_i,
  input  wire [3:0] pll_multiplier_select_i,
  input  wire       external_ref_output_enable_i,
  input  wire       external_ref_stop_enable_i,
  input  wire       oscillator_select_i,
  input  wire       clock_monitor_enable_i,
  input  wire       range_i,
  input  wire       loss_flag_clear_i,
  output reg        external_ref_clock_output_o,
  output reg        fixed_frequency_clock_o,
  output reg        fixed_clock_valid_indicator_o,
  output reg        main_output_tick_o,
  output reg        bus_clock_tick_o,
  output reg        debug_link_tick_o,
  output reg  [1:0] clock_source_status_o,
  output reg        internal_ref_status_o,
  output reg        loop_select_status_o,
  output reg        lock_o,
  output reg        oscillator_initialized_flag_o,
  output reg  [2:0] mode_o,
  output reg        mcu_reset_request_o,
  output reg        loss_of_clock_flag_o
);
  reg  [1:0]  clock_source_select_r;
  reg         internal_ref_select_r;
  reg         loop_select_r;
  reg         lp_r;
  reg  [2:0]  reference_divider_r;
  reg  [1:0]  bus_frequency_divider_r;
  reg  [3:0]  pll_multiplier_select_r;
  reg         external_ref_output_enable_r;
  reg         external_ref_stop_enable_r;
  reg         oscillator_select_r;
  reg         cme_r;
  reg         range_r;
  reg         ext_s1_r;
  reg         ext_s2_r;
  reg         ext_s3_r;
  reg  [15:0] loc_cnt_r;
  reg         edge_seen_r;
  reg  [11:0] osc_cnt_r;
  reg  [11:0] int_cnt_r;
  reg         int_tick_r;
  reg  [15:0] per_cnt_r;
  reg  [15:0] period_r;
  reg  [16:0] acc_r;
  reg         loop_tick_r;
  reg         bus_phase_r;
  reg         main_src_tick;
  reg  [16:0] acc_nxt;
  reg         loop_tick_nxt;
  wire [2:0]  mode_w;
  wire        ext_tick;
  wire        ext_keep;
  wire        ext_run;
  wire        ext_lost;
  wire        ext_ok;
  wire        loop_en;
  wire        ref_tick;
  wire        refdiv_tick;
  wire        main_div_tick;
  wire [15:0] loc_limit;
  wire [10:0] loop_factor_w;
  wire [16:0] acc_sum;
  wire [15:0] period_diff;
  wire [1:0]  clock_source_select_req;
  wire        clock_source_select_avail;
  wire        loss_event;

  function [2:0] decode_mode;
    input [1:0] clock_source_select;
    input       internal_ref_select;
    input       loop_select;
    input       lp;
    input       dbg;
    begin
      case (clock_source_select)
        `CLOCK_SOURCE_SELECT_INTERNAL: decode_mode = (lp && !dbg) ? `MODE_LOW_POWER_BYPASSED_INTERNAL_MODE : `MODE_FBI;
        `CLOCK_SOURCE_SELECT_EXTERNAL: decode_mode = (lp && !dbg) ? `MODE_LOW_POWER_BYPASSED_EXTERNAL_MODE :
                                      (loop_select ? `MODE_PBE : `MODE_FBE);
        default:        decode_mode = loop_select ? `MODE_PEE :
                                      (internal_ref_select ? `MODE_FEI : `MODE_FEE);
      endcase
    end
  endfunction

  function is_bypass;
    input [2:0] mode;
    begin
      is_bypass = (mode == `MODE_FBI) || (mode == `MODE_FBE) || (mode == `MODE_PBE) ||
                  (mode == `MODE_LOW_POWER_BYPASSED_INTERNAL_MODE) || (mode == `MODE_LOW_POWER_BYPASSED_EXTERNAL_MODE);
    end
  endfunction

  function is_external;
    input [2:0] mode;
    begin
      is_external = (mode == `MODE_FEE) || (mode == `MODE_FBE) || (mode == `MODE_PEE) ||
                    (mode == `MODE_PBE) || (mode == `MODE_LOW_POWER_BYPASSED_EXTERNAL_MODE);
    end
  endfunction

  assign mode_w   = decode_mode(clock_source_select_r, internal_ref_select_r, loop_select_r, lp_r, debug_active_i);
  assign ext_tick = ext_s2_r & ~ext_s3_r;
  assign ext_keep = (external_ref_output_enable_r & external_ref_stop_enable_r) | is_external(mode_w);
  assign ext_run  = ~stop_i | ext_keep;
  assign loc_limit = range_r ? LOC_CYCLES_HIGH : LOC_CYCLES_LOW;
  assign ext_lost = (loc_cnt_r == loc_limit);
  assign ext_ok   = oscillator_select_r ? oscillator_initialized_flag_o : (edge_seen_r & ~ext_lost);
  // Low-power bypass modes and stop keep both loops powered down
  assign loop_en  = ~stop_i & (mode_w != `MODE_LOW_POWER_BYPASSED_INTERNAL_MODE) & (mode_w != `MODE_LOW_POWER_BYPASSED_EXTERNAL_MODE);
  // External edges only reach the loop reference once the switch is done
  assign ref_tick = internal_ref_status_o ? int_tick_r : (ext_tick & ext_run);
  assign loop_factor_w = loop_select_status_o ?
                         {5'h00, pll_multiplier_select_r, 2'h0} : `FLL_FACTOR;
  assign acc_sum  = acc_r + {6'h00, loop_factor_w};
  assign period_diff = (per_cnt_r >= period_r) ? (per_cnt_r - period_r) :
                       (period_r - per_cnt_r);
  assign clock_source_select_req = (clock_source_select_r == `CLOCK_SOURCE_SELECT_INTERNAL || clock_source_select_r == `CLOCK_SOURCE_SELECT_EXTERNAL) ? clock_source_select_r :
                    (loop_select_status_o ? `CLOCK_SOURCE_SELECT_PLL : `CLOCK_SOURCE_SELECT_LOOP);
  assign clock_source_select_avail = (clock_source_select_req == `CLOCK_SOURCE_SELECT_INTERNAL) ? 1'b1 :
                      (clock_source_select_req == `CLOCK_SOURCE_SELECT_EXTERNAL) ? (ext_ok & ext_run) :
                      (loop_en & lock_o);
  assign loss_event = cme_r & edge_seen_r & ext_lost & ~stop_i;

  tick_power2_divider ref_divider (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .tick_i  (ref_tick),
    .code_i  (reference_divider_r),
    .tick_o  (refdiv_tick)
  );

  tick_power2_divider bus_divider (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .tick_i  (main_src_tick),
    .code_i  ({1'b0, bus_frequency_divider_r}),
    .tick_o  (main_div_tick)
  );

  always @*
  begin
    case (clock_source_status_o)
      `CLOCK_SOURCE_SELECT_INTERNAL: main_src_tick = int_tick_r & ~stop_i;
      `CLOCK_SOURCE_SELECT_EXTERNAL: main_src_tick = ext_tick & ~stop_i;
      default:        main_src_tick = loop_tick_r & ~stop_i;
    endcase
  end

  // Spreads factor ticks over each measured reference period; a factor at or above the period gives a tick every cycle
  always @*
  begin
    acc_nxt = acc_r;
    loop_tick_nxt = 1'b0;
    if (!loop_en || period_r == 16'h0000)
    begin
      acc_nxt = 17'h00000;
    end
    else if ({6'h00, loop_factor_w} >= {1'b0, period_r})
    begin
      acc_nxt = 17'h00000;
      loop_tick_nxt = 1'b1;
    end
    else if (acc_sum >= {1'b0, period_r})
    begin
      acc_nxt = acc_sum - {1'b0, period_r};
      loop_tick_nxt = 1'b1;
    end
    else
    begin
      acc_nxt = acc_sum;
    end
  end

  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      clock_source_select_r     <= `RST_CLOCK_SOURCE_SELECT;
      internal_ref_select_r    <= `RST_INTERNAL_REF_SELECT;
      loop_select_r     <= 1'b0;
      lp_r       <= 1'b0;
      reference_divider_r     <= `RST_REFERENCE_DIVIDER;
      bus_frequency_divider_r     <= `RST_BUS_FREQUENCY_DIVIDER;
      pll_multiplier_select_r     <= `RST_PLL_MULTIPLIER_SELECT;
      external_ref_output_enable_r  <= 1'b0;
      external_ref_stop_enable_r <= 1'b0;
      oscillator_select_r    <= 1'b0;
      cme_r      <= 1'b0;
      range_r    <= 1'b0;
    end
    else if (control_write_i)
    begin
      clock_source_select_r     <= clock_source_select_i;
      internal_ref_select_r    <= internal_ref_select_i;
      loop_select_r     <= loop_select_i;
      lp_r       <= low_power_i;
      reference_divider_r     <= reference_divider_i;
      bus_frequency_divider_r     <= bus_frequency_divider_i;
      pll_multiplier_select_r     <= pll_multiplier_select_i;
      external_ref_output_enable_r  <= external_ref_output_enable_i;
      external_ref_stop_enable_r <= external_ref_stop_enable_i;
      oscillator_select_r    <= oscillator_select_i;
      cme_r      <= clock_monitor_enable_i;
      range_r    <= range_i;
    end
  end

  always @(posedge clk_i)
  begin
    ext_s1_r <= ext_ref_clock_i;
    ext_s2_r <= ext_s1_r;
    ext_s3_r <= ext_s2_r;
  end

  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      loc_cnt_r <= 16'h0000;
      edge_seen_r <= 1'b0;
      osc_cnt_r <= 12'h000;
      oscillator_initialized_flag_o <= 1'b0;
      int_cnt_r <= 12'h000;
      int_tick_r <= 1'b0;
    end
    else
    begin
      if (ext_tick)
      begin
        loc_cnt_r <= 16'h0000;
        edge_seen_r <= 1'b1;
      end
      else if (!ext_lost)
      begin
        loc_cnt_r <= loc_cnt_r + 16'h0001;
      end
      if (!oscillator_select_r || !(external_ref_output_enable_r || is_external(mode_w)) || ext_lost || !ext_run)
      begin
        osc_cnt_r <= 12'h000;
        oscillator_initialized_flag_o <= 1'b0;
      end
      else if (ext_tick && !oscillator_initialized_flag_o)
      begin
        osc_cnt_r <= osc_cnt_r + 12'h001;
        oscillator_initialized_flag_o <= (osc_cnt_r == `OSC_STARTUP_LAST);
      end
      int_tick_r <= (int_cnt_r == `INT_REF_CYCLES - 1);
      int_cnt_r  <= (int_cnt_r == `INT_REF_CYCLES - 1) ? 12'h000 : int_cnt_r + 12'h001;
    end
  end

  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      per_cnt_r <= 16'h0000;
      period_r <= 16'h0000;
      lock_o <= 1'b0;
      loop_select_status_o <= 1'b0;
      internal_ref_status_o <= 1'b1;
      clock_source_status_o <= `CLOCK_SOURCE_SELECT_LOOP;
      acc_r <= 17'h00000;
      loop_tick_r <= 1'b0;
    end
    else
    begin
      acc_r <= acc_nxt;
      loop_tick_r <= loop_tick_nxt;
      if (refdiv_tick)
      begin
        per_cnt_r <= 16'h0000;
        period_r <= per_cnt_r;
        loop_select_status_o <= loop_select_r;
        lock_o <= loop_en && (period_r != 16'h0000) && (period_diff <= `LOCK_TOLERANCE);
      end
      else
      begin
        if (per_cnt_r != 16'hffff)
        begin
          per_cnt_r <= per_cnt_r + 16'h0001;
        end
        if (!loop_en)
        begin
          lock_o <= 1'b0;
        end
      end
      if (internal_ref_select_r)
      begin
        internal_ref_status_o <= 1'b1;
      end
      else if (ext_ok)
      begin
        internal_ref_status_o <= 1'b0;
      end
      // An unavailable source leaves the previous one selected
      if (clock_source_select_avail)
      begin
        clock_source_status_o <= clock_source_select_req;
      end
    end
  end

  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      external_ref_clock_output_o <= 1'b0;
      fixed_frequency_clock_o <= 1'b0;
      fixed_clock_valid_indicator_o <= 1'b1;
      main_output_tick_o <= 1'b0;
      bus_clock_tick_o <= 1'b0;
      bus_phase_r <= 1'b0;
      debug_link_tick_o <= 1'b0;
      mode_o <= `MODE_FEI;
    end
    else
    begin
      external_ref_clock_output_o <= ext_s2_r & external_ref_output_enable_r & ext_run;
      if (refdiv_tick)
      begin
        fixed_frequency_clock_o <= ~fixed_frequency_clock_o;
      end
      fixed_clock_valid_indicator_o <= ~(is_bypass(mode_w) &&
        (((bus_frequency_divider_r == `BUS_FREQUENCY_DIVIDER_DIV1) && (reference_divider_r < `REFERENCE_DIVIDER_MIN_DIV1)) ||
         ((bus_frequency_divider_r == `BUS_FREQUENCY_DIVIDER_DIV2) && (reference_divider_r < `REFERENCE_DIVIDER_MIN_DIV2))));
      main_output_tick_o <= main_div_tick;
      if (main_div_tick)
      begin
        bus_phase_r <= ~bus_phase_r;
      end
      bus_clock_tick_o <= main_div_tick & bus_phase_r;
      debug_link_tick_o <= loop_tick_r & loop_en & debug_active_i;
      mode_o <= mode_w;
    end
  end

  // Loss flag survives the reset it causes; only power-on or software clears it
  always @(posedge clk_i)
  begin
    if (power_on_i)
    begin
      mcu_reset_request_o <= 1'b0;
      loss_of_clock_flag_o <= 1'b0;
    end
    else if (reset_i)
    begin
      mcu_reset_request_o <= 1'b0;
    end
    else
    begin
      if (loss_event)
      begin
        mcu_reset_request_o <= 1'b1;
      end
      loss_of_clock_flag_o <= loss_event | (loss_of_clock_flag_o & ~loss_flag_clear_i);
    end
  end
endmodule

// *** dv/ext_ref_source.sv ***
// Behavioural external clock source that stands low while stopped
`timescale 1ns/10ps
module ext_ref_source (
  input  wire logic run_i,
  input  wire logic fast_i,
  output logic      ref_o
);
  // 5 MHz suits the FLL external range; 12.5 MHz only the low-power bypass range
  initial ref_o = 1'b0;
  always
  begin
    #(fast_i ? 40 : 100);
    ref_o = run_i ? ~ref_o : 1'b0;
  end
endmodule

// *** dv/clock_generator_asserts.sv ***
// Port-level checker for the clock generator
`timescale 1ns/10ps
module clock_generator_asserts #(
  parameter [15:0] LOC_CYCLES_LOW  = 16'h2710,
  parameter [15:0] LOC_CYCLES_HIGH = 16'h03e8
) (
  input wire logic       clk_i,
  input wire logic       reset_i,
  input wire logic       control_write_i,
  input wire logic       stop_i,
  input wire logic [1:0] clock_source_select_i,
  input wire logic [2:0] reference_divider_i,
  input wire logic [1:0] bus_frequency_divider_i,
  input wire logic       external_ref_output_enable_i,
  input wire logic       external_ref_stop_enable_i,
  input wire logic       oscillator_select_i,
  input wire logic       clock_monitor_enable_i,
  input wire logic       external_ref_clock_output_o,
  input wire logic       fixed_clock_valid_indicator_o,
  input wire logic       main_output_tick_o,
  input wire logic       bus_clock_tick_o,
  input wire logic       debug_link_tick_o,
  input wire logic [1:0] clock_source_status_o,
  input wire logic       lock_o,
  input wire logic       oscillator_initialized_flag_o,
  input wire logic [2:0] mode_o,
  input wire logic       mcu_reset_request_o,
  input wire logic       loss_of_clock_flag_o
);
  logic [10:0] c_r;
  logic [1:0]  mcnt_r;
  logic        seen_r;
  wire         byp  = mode_o == 3'h2 || mode_o == 3'h3 || mode_o >= 3'h5;
  wire         bad  = (c_r[5:4] == 2'h0 && c_r[8:6] < 3'h2) ||
                      (c_r[5:4] == 2'h1 && c_r[8:6] < 3'h3);
  wire         keep = (c_r[3] && c_r[2]) || mode_o[0] || mode_o == 3'h4;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  // Only ports are visible, so the latched controls are shadowed here
  always @(posedge clk_i)
  begin
    if (reset_i)
      c_r <= 11'h010;
    else if (control_write_i)
      c_r <= {clock_source_select_i, reference_divider_i, bus_frequency_divider_i,
              external_ref_output_enable_i, external_ref_stop_enable_i,
              oscillator_select_i, clock_monitor_enable_i};
  end
  // Main ticks since the last bus tick; the first bus tick has no reference
  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      mcnt_r <= 2'h0;
      seen_r <= 1'b0;
    end
    else if (bus_clock_tick_o)
    begin
      mcnt_r <= 2'h0;
      seen_r <= 1'b1;
    end
    else
      mcnt_r <= mcnt_r + {1'b0, main_output_tick_o};
  end
  a_reset_mode: assert property ($fell(reset_i) |-> mode_o == 3'h0 && clock_source_status_o == 2'h0)
    else $error("mode or source status wrong after reset");
  a_valid_low: assert property ((byp && bad) [*4] |-> !fixed_clock_valid_indicator_o)
    else $error("fixed clock valid in a bad bypass setting");
  a_valid_high: assert property ((!(byp && bad)) [*4] |-> fixed_clock_valid_indicator_o)
    else $error("fixed clock invalid in a good setting");
  a_out_gate: assert property ((!c_r[3]) [*4] |-> !external_ref_clock_output_o)
    else $error("external output active while disabled");
  a_stop_drop: assert property ((stop_i && !keep) [*4] |-> !external_ref_clock_output_o)
    else $error("external output active in stop");
  a_loss_flag: assert property ($rose(mcu_reset_request_o) |-> loss_of_clock_flag_o && $past(c_r[0]))
    else $error("reset request without flag or monitor");
  a_lp_debug: assert property ((mode_o[2:1] == 2'h3) [*2] |-> !debug_link_tick_o)
    else $error("debug tick in low-power mode");
  a_lp_lock: assert property ((mode_o[2:1] == 2'h3) [*3] |-> !lock_o)
    else $error("lock held in low-power mode");
  a_source_req: assert property ($changed(clock_source_status_o) && clock_source_status_o inside {2'h1, 2'h2}
    |-> clock_source_status_o == c_r[10:9])
    else $error("source status differs from request");
  a_osc_sel: assert property ($rose(oscillator_initialized_flag_o) |-> c_r[1])
    else $error("oscillator flag without crystal");
  a_bus_half: assert property (bus_clock_tick_o && seen_r |-> mcnt_r + {1'b0, main_output_tick_o} == 2'h2)
    else $error("bus tick not every second main tick");
endmodule
bind clock_generator clock_generator_asserts #(
  .LOC_CYCLES_LOW(LOC_CYCLES_LOW),
  .LOC_CYCLES_HIGH(LOC_CYCLES_HIGH)
) u_chk (.*);

// *** dv/clock_generator_tb.sv ***
// Self-checking bench for the clock generator
`timescale 1ns/10ps
module clock_generator_tb;
  logic       clk_i = 1'b0;
  logic       reset_i = 1'b1;
  logic       power_on_i = 1'b1;
  logic       stop_i = 1'b0;
  logic       debug_active_i = 1'b0;
  logic       control_write_i = 1'b0;
  logic [1:0] clock_source_select_i = 2'h0;
  logic       internal_ref_select_i = 1'b1;
  logic       loop_select_i = 1'b0;
  logic       low_power_i = 1'b0;
  logic [2:0] reference_divider_i = 3'h0;
  logic [1:0] bus_frequency_divider_i = 2'h1;
  logic [3:0] pll_multiplier_select_i = 4'h1;
  logic       external_ref_output_enable_i = 1'b0;
  logic       external_ref_stop_enable_i = 1'b0;
  logic       oscillator_select_i = 1'b0;
  logic       clock_monitor_enable_i = 1'b0;
  logic       range_i = 1'b1;
  logic       loss_flag_clear_i = 1'b0;
  logic       run = 1'b1;
  logic       fast = 1'b0;
  logic [2:0] rd [4] = '{3'h0, 3'h3, 3'h1, 3'h2};
  wire        ext_ref_clock_i;
  wire        external_ref_clock_output_o, fixed_frequency_clock_o;
  wire        fixed_clock_valid_indicator_o, main_output_tick_o, bus_clock_tick_o;
  wire        debug_link_tick_o, internal_ref_status_o, loop_select_status_o, lock_o;
  wire        oscillator_initialized_flag_o, mcu_reset_request_o, loss_of_clock_flag_o;
  wire [1:0]  clock_source_status_o;
  wire [2:0]  mode_o;
  int         fail_count = 0;
  int         num_checks = 0;
  int         i, nr, nm, nb, nf;
  always #5 clk_i = ~clk_i;
  ext_ref_source src (.run_i(run), .fast_i(fast), .ref_o(ext_ref_clock_i));
  // Short loss windows keep the monitor scenario quick
  clock_generator #(.LOC_CYCLES_LOW(16'h00c8), .LOC_CYCLES_HIGH(16'h0032)) dut (.*);
  task cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task wr;
    control_write_i = 1'b1;
    cyc(1);
    control_write_i = 1'b0;
    cyc(6);
  endtask
  task chk(input string n, input logic [3:0] e, input logic [3:0] g);
    num_checks++;
    if (e !== g)
    begin
      fail_count++;
      $display("wrong value %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task rng(input string n, input int lo, input int hi, input int g);
    num_checks++;
    if (g < lo || g > hi)
    begin
      fail_count++;
      $display("wrong value %s expected %0d to %0d seen %0d", n, lo, hi, g);
    end
  endtask
  task cnt(input int n);
    logic p;
    logic q;
    nr = 0;
    nm = 0;
    nb = 0;
    nf = 0;
    p = external_ref_clock_output_o;
    q = fixed_frequency_clock_o;
    repeat (n)
    begin
      cyc(1);
      nr += int'(external_ref_clock_output_o && !p);
      nm += int'(main_output_tick_o);
      nb += int'(bus_clock_tick_o);
      nf += int'(fixed_frequency_clock_o && !q);
      p = external_ref_clock_output_o;
      q = fixed_frequency_clock_o;
    end
  endtask
  task results;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task t_reset;
    chk("mode", 4'h0, mode_o);
    chk("source status", 4'h0, clock_source_status_o);
    chk("ref status", 4'h1, internal_ref_status_o);
    chk("valid", 4'h1, fixed_clock_valid_indicator_o);
  endtask
  task t_fbi;
    clock_source_select_i = 2'h1;
    wr;
    for (i = 0; i < 8000 && clock_source_status_o !== 2'h1; i++)
      cyc(1);
    chk("source status", 4'h1, clock_source_status_o);
    chk("mode", 4'h2, mode_o);
    for (i = 0; i < 4; i++)
    begin
      bus_frequency_divider_i = {1'b0, ~i[1]};
      reference_divider_i = rd[i];
      wr;
      chk("valid", {3'h0, i[0]}, fixed_clock_valid_indicator_o);
    end
    bus_frequency_divider_i = 2'h1;
    reference_divider_i = 3'h0;
    external_ref_output_enable_i = 1'b1;
    wr;
    cnt(400);
    rng("ext out edges", 19, 21, nr);
    stop_i = 1'b1;
    cyc(4);
    cnt(400);
    rng("ext out edges in stop", 0, 0, nr);
    external_ref_stop_enable_i = 1'b1;
    wr;
    cnt(400);
    rng("ext out edges in stop", 19, 21, nr);
    stop_i = 1'b0;
    external_ref_stop_enable_i = 1'b0;
  endtask
  task t_fbe;
    internal_ref_select_i = 1'b0;
    clock_source_select_i = 2'h2;
    wr;
    for (i = 0; i < 20000 && !(lock_o === 1'b1 && clock_source_status_o === 2'h2); i++)
      cyc(1);
    chk("source status", 4'h2, clock_source_status_o);
    chk("ref status", 4'h0, internal_ref_status_o);
    chk("lock", 4'h1, lock_o);
    chk("mode", 4'h3, mode_o);
    chk("loop status", 4'h0, loop_select_status_o);
    cnt(400);
    rng("main ticks", 9, 11, nm);
    rng("fixed clock edges", 9, 11, nf);
    rng("bus ticks", nm / 2, (nm + 1) / 2, nb);
  endtask
  task t_low_power_bypassed_external_mode;
    fast = 1'b1;
    low_power_i = 1'b1;
    oscillator_select_i = 1'b1;
    wr;
    chk("mode", 4'h7, mode_o);
    chk("lock", 4'h0, lock_o);
    cyc(2000);
    chk("osc flag early", 4'h0, oscillator_initialized_flag_o);
    for (i = 0; i < 40000 && oscillator_initialized_flag_o !== 1'b1; i++)
      cyc(1);
    chk("osc flag", 4'h1, oscillator_initialized_flag_o);
  endtask
  task t_loss;
    clock_monitor_enable_i = 1'b1;
    wr;
    chk("reset request", 4'h0, mcu_reset_request_o);
    run = 1'b0;
    for (i = 0; i < 300 && mcu_reset_request_o !== 1'b1; i++)
      cyc(1);
    chk("reset request", 4'h1, mcu_reset_request_o);
    chk("loss flag", 4'h1, loss_of_clock_flag_o);
    reset_i = 1'b1;
    power_on_i = 1'b1;
    cyc(2);
    reset_i = 1'b0;
    power_on_i = 1'b0;
    cyc(1);
    chk("loss flag", 4'h0, loss_of_clock_flag_o);
    t_reset;
  endtask
  initial
  begin
    #1000000;
    fail_count++;
    results;
  end
  initial
  begin
    cyc(2);
    reset_i = 1'b0;
    // No trim port: the software trim copy has no target here
    power_on_i = 1'b0;
    cyc(1);
    t_reset;
    t_fbi;
    t_fbe;
    t_low_power_bypassed_external_mode;
    t_loss;
    results;
  end
endmodule
